// ==== logic/ofd_decoder.v ====
// operand field decoder with avalon-mm register access
//
// Function
// - two-bit selector: 00 direct, 01 immediate, 10 indirect, 11 indexed.
// - selector decoded only for opcodes offering an addressing choice.
// - three-bit field in bit opcodes indexes the bit tested or changed.
// - bit-number field picks exactly one of eight byte bit positions.
// - byte register operands may use any address 00 to FFH.
// - word operands sit at even addresses 00 to FEH.
// - long, triple, pointer and pair operands align to four, 00 to FCH.
// - block-move double pointer aligns to eight, 00 to F8H.
// - three-byte operand is a 24-bit value at a four-aligned address.
// - pointer pair is two independent 16-bit halves; long is one 32-bit.
// - branch target is signed displacement plus next instruction address.
// - displacement extension field gives the displacement's top bits.
// - normal mode writes the flag from the result.
// - unmodified mode keeps the flag.
// - clear-only mode may clear, never set.
// - set-only mode may set, never clear.
// - forced mode writes one or zero unconditionally.
// - indeterminate mode leaves any value.
// - trap flag follows overflow set; only trap instructions clear it (here a write to the flags register with overflow and trap bits clear also clears it).
//
// Design decisions made here: the Avalon-MM register port and the register offsets.
`default_nettype none

module ofd_decoder #(
   parameter AW = 6,
   parameter NF = 6
) (
   input wire clk,
   input wire nrst,
   input wire [AW-1:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   input wire [3:0] byteenable,
   output reg [31:0] readdata,
   output reg waitrequest,
   output reg [NF-1:0] flag_word,
   output reg misaligned,
   output reg [15:0] branch_target
);
`include "ofd_map.vh"

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function [31:0] merge_be;
      input [31:0] old;
      input [31:0] wd;
      input [3:0] be;
      integer k;
      begin
         for (k = 0; k < 4; k = k + 1) begin
            merge_be[8*k +: 8] = be[k] ? wd[8*k +: 8] : old[8*k +: 8];
         end
      end
   endfunction

   // address range is implicit in the 8-bit field; only alignment or an undefined kind can fail
   function align_ok;
      input [7:0] a;
      input [2:0] kind;
      begin
         case (kind)
            `OFD_KIND_BYTE: align_ok = 1'b1;
            `OFD_KIND_WORD: align_ok = (a[0] == 1'b0);
            `OFD_KIND_LONG: align_ok = (a[1:0] == 2'h0);
            `OFD_KIND_TRIPLE: align_ok = (a[1:0] == 2'h0);
            `OFD_KIND_PTR: align_ok = (a[1:0] == 2'h0);
            `OFD_KIND_PAIR: align_ok = (a[1:0] == 2'h0);
            `OFD_KIND_DPTR: align_ok = (a[2:0] == 3'h0);
            default: align_ok = 1'b0;
         endcase
      end
   endfunction

   // ---------------------------------------------------------------
   // software-visible registers
   // ---------------------------------------------------------------
   reg [31:0] insn_reg;
   reg [31:0] operand_reg;
   reg [31:0] branch_reg;
   reg [31:0] opdata_reg;
   reg [NF-1:0] flags_reg;
   reg [31:0] upd_reg;

   // ---------------------------------------------------------------
   // field extraction
   // ---------------------------------------------------------------
   wire [7:0] opcode;
   wire [2:0] op_class;
   wire [7:0] op_addr;
   wire [2:0] op_kind;
   wire [15:0] next_addr;
   wire [7:0] disp_low;

   assign opcode = insn_reg[7:0];
   assign op_class = insn_reg[`OFD_CLS_LSB +: 3];
   assign op_addr = operand_reg[7:0];
   assign op_kind = operand_reg[`OFD_KIND_LSB +: 3];
   assign next_addr = branch_reg[15:0];
   assign disp_low = branch_reg[`OFD_DISP_LSB +: 8];

   // ---------------------------------------------------------------
   // addressing selector
   // ---------------------------------------------------------------
   reg [1:0] am_sel;
   reg am_valid;

   always @* begin
      am_sel = `OFD_AM_DIRECT;
      am_valid = 1'b0;
      // other opcodes use these bits for something else
      if (op_class == `OFD_CLS_MODE) begin
         am_valid = 1'b1;
         case (opcode[1:0])
            2'h0: am_sel = `OFD_AM_DIRECT;
            2'h1: am_sel = `OFD_AM_IMMED;
            2'h2: am_sel = `OFD_AM_INDIRECT;
            2'h3: am_sel = `OFD_AM_INDEXED;
            default: am_sel = `OFD_AM_DIRECT;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // bit select
   // ---------------------------------------------------------------
   reg [2:0] bit_idx;
   reg [7:0] bit_mask;
   reg bit_valid;

   always @* begin
      bit_idx = 3'h0;
      bit_mask = 8'h00;
      bit_valid = 1'b0;
      if (op_class == `OFD_CLS_BIT) begin
         bit_valid = 1'b1;
         bit_idx = opcode[2:0];
         bit_mask = 8'h01 << opcode[2:0];
      end
   end

   // ---------------------------------------------------------------
   // displacement and branch target
   // ---------------------------------------------------------------
   reg [15:0] disp_ext;
   reg [15:0] target_calc;

   always @* begin
      if (op_class == `OFD_CLS_DISPX) begin
         // eleven-bit displacement, extension bits on top
         disp_ext = {{5{opcode[2]}}, opcode[2:0], disp_low};
      end else begin
         disp_ext = {{8{disp_low[7]}}, disp_low};
      end
      // counted from the end of the instruction, not its start
      target_calc = next_addr + disp_ext;
   end

   // ---------------------------------------------------------------
   // operand alignment and stepping
   // ---------------------------------------------------------------
   wire align_good;
   reg [31:0] step_calc;

   assign align_good = align_ok(op_addr, op_kind);

   always @* begin
      case (op_kind)
         // halves wrap on their own; no carry from low to high
         `OFD_KIND_PAIR: begin
            step_calc = {opdata_reg[31:16] + 16'h0001,
                         opdata_reg[15:0] + 16'h0001};
         end
         `OFD_KIND_LONG: begin
            step_calc = opdata_reg + 32'h00000001;
         end
         `OFD_KIND_TRIPLE: begin
            step_calc = {8'h00, opdata_reg[23:0] + 24'h000001};
         end
         default: begin
            step_calc = opdata_reg;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // flag update engine
   // ---------------------------------------------------------------
   wire [NF-1:0] flags_upd;

   ofd_flag_unit #(
      .NF(NF)
   ) u_flags (
      .flags_cur(flags_reg),
      .modes(upd_reg[3*NF-1:0]),
      .result(upd_reg[`OFD_UPD_RES_LSB +: NF]),
      .trap_clear(upd_reg[`OFD_UPD_TRAPCLR]),
      .flags_next(flags_upd)
   );

   // ---------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------
   reg [31:0] rd_next;

   always @* begin
      rd_next = 32'h00000000;
      case (address)
         `OFD_OFF_INSN: rd_next = insn_reg;
         `OFD_OFF_OPERAND: rd_next = operand_reg;
         `OFD_OFF_BRANCH: rd_next = branch_reg;
         `OFD_OFF_DECODE: begin
            rd_next = {16'h0000, ~align_good, bit_mask, bit_idx,
                       bit_valid, am_valid, am_sel};
         end
         `OFD_OFF_TARGET: rd_next = {16'h0000, target_calc};
         `OFD_OFF_FLAGS: rd_next = {{(32-NF){1'b0}}, flags_reg};
         `OFD_OFF_FLAGUPD: rd_next = upd_reg;
         `OFD_OFF_OPDATA: rd_next = opdata_reg;
         `OFD_OFF_STEP: rd_next = step_calc;
         default: rd_next = 32'h00000000;
      endcase
   end

   // ---------------------------------------------------------------
   // bus handshake
   // ---------------------------------------------------------------
   // one wait state: the data is ready the cycle after the request
   // readdata loads on writes as well; cheaper than a direction check
   wire req;
   wire wr_go;
   wire upd_go;

   assign req = read | write;
   assign wr_go = write & ~waitrequest;
   assign upd_go = wr_go & (address == `OFD_OFF_FLAGUPD);

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         waitrequest <= 1'b1;
         readdata <= `OFD_RST_WORD;
      end else begin
         if (req && waitrequest) begin
            waitrequest <= 1'b0;
            readdata <= rd_next;
         end else begin
            waitrequest <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // register writes
   // ---------------------------------------------------------------
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         insn_reg <= `OFD_RST_WORD;
         operand_reg <= `OFD_RST_WORD;
         branch_reg <= `OFD_RST_WORD;
         opdata_reg <= `OFD_RST_WORD;
         upd_reg <= `OFD_RST_WORD;
      end else if (wr_go) begin
         case (address)
            `OFD_OFF_INSN: begin
               insn_reg <= merge_be(insn_reg, writedata, byteenable);
            end
            `OFD_OFF_OPERAND: begin
               operand_reg <= merge_be(operand_reg, writedata, byteenable);
            end
            `OFD_OFF_BRANCH: begin
               branch_reg <= merge_be(branch_reg, writedata, byteenable);
            end
            `OFD_OFF_OPDATA: begin
               opdata_reg <= merge_be(opdata_reg, writedata, byteenable);
            end
            `OFD_OFF_FLAGUPD: begin
               upd_reg <= merge_be(upd_reg, writedata, byteenable);
            end
            default: begin
               insn_reg <= insn_reg;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // status word
   // ---------------------------------------------------------------
   // the update applies with the value being written, one cycle early
   wire [31:0] upd_new;
   wire [NF-1:0] flags_now;

   assign upd_new = merge_be(upd_reg, writedata, byteenable);

   ofd_flag_unit #(
      .NF(NF)
   ) u_flags_now (
      .flags_cur(flags_reg),
      .modes(upd_new[3*NF-1:0]),
      .result(upd_new[`OFD_UPD_RES_LSB +: NF]),
      .trap_clear(upd_new[`OFD_UPD_TRAPCLR]),
      .flags_next(flags_now)
   );

   // a written overflow drags the trap flag along, so the pair never disagrees
   wire [NF-1:0] flags_wr;

   assign flags_wr = writedata[NF-1:0] |
      ({{(NF-1){1'b0}}, writedata[`OFD_FLAG_V]} << `OFD_FLAG_TRAP);

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         flags_reg <= `OFD_RST_FLAGS;
      end else if (upd_go) begin
         flags_reg <= flags_now;
      end else if (wr_go && address == `OFD_OFF_FLAGS) begin
         flags_reg <= flags_wr;
      end
   end

   // ---------------------------------------------------------------
   // registered outputs
   // ---------------------------------------------------------------
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         flag_word <= `OFD_RST_FLAGS;
         misaligned <= 1'b0;
         branch_target <= 16'h0000;
      end else begin
         flag_word <= flags_reg;
         // flagged only; the address is passed on unchanged
         misaligned <= ~align_good;
         branch_target <= target_calc;
      end
   end

endmodule
`default_nettype wire

// ==== shared/ofd_map.vh ====
// register map, field layout and encodings of the operand field decoder
`ifndef OFD_MAP_VH
`define OFD_MAP_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define OFD_OFF_INSN     6'h00
`define OFD_OFF_OPERAND  6'h04
`define OFD_OFF_BRANCH   6'h08
`define OFD_OFF_DECODE   6'h0C
`define OFD_OFF_TARGET   6'h10
`define OFD_OFF_FLAGS    6'h14
`define OFD_OFF_FLAGUPD  6'h18
`define OFD_OFF_OPDATA   6'h1C
`define OFD_OFF_STEP     6'h20

// ---------------------------------------------------------------
// opcode class, written in insn[10:8]
// ---------------------------------------------------------------
`define OFD_CLS_PLAIN    3'h0
`define OFD_CLS_MODE     3'h1
`define OFD_CLS_BIT      3'h2
`define OFD_CLS_DISPX    3'h3

// ---------------------------------------------------------------
// operand kind, written in operand[10:8]
// ---------------------------------------------------------------
`define OFD_KIND_BYTE    3'h0
`define OFD_KIND_WORD    3'h1
`define OFD_KIND_LONG    3'h2
`define OFD_KIND_TRIPLE  3'h3
`define OFD_KIND_PTR     3'h4
`define OFD_KIND_PAIR    3'h5
`define OFD_KIND_DPTR    3'h6

// ---------------------------------------------------------------
// addressing selector codes
// ---------------------------------------------------------------
`define OFD_AM_DIRECT    2'h0
`define OFD_AM_IMMED     2'h1
`define OFD_AM_INDIRECT  2'h2
`define OFD_AM_INDEXED   2'h3

// ---------------------------------------------------------------
// flag update modes, three bits per flag
// ---------------------------------------------------------------
`define OFD_FM_NORMAL    3'h0
`define OFD_FM_KEEP      3'h1
`define OFD_FM_CLRONLY   3'h2
`define OFD_FM_SETONLY   3'h3
`define OFD_FM_FORCE1    3'h4
`define OFD_FM_FORCE0    3'h5
`define OFD_FM_UNDEF     3'h6

// ---------------------------------------------------------------
// flag positions in the status word
// ---------------------------------------------------------------
`define OFD_FLAG_ST      0
`define OFD_FLAG_TRAP    1
`define OFD_FLAG_V       2
`define OFD_FLAG_C       3
`define OFD_FLAG_N       4
`define OFD_FLAG_Z       5
`define OFD_NFLAGS       6

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define OFD_UPD_RES_LSB  18
`define OFD_UPD_TRAPCLR  24
`define OFD_CLS_LSB      8
`define OFD_KIND_LSB     8
`define OFD_DISP_LSB     16

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define OFD_RST_WORD     32'h00000000
`define OFD_RST_FLAGS    6'h00

`endif

// ==== logic/ofd_flag_unit.v ====
// per-flag update engine for the status word
`default_nettype none

module ofd_flag_unit #(
   parameter NF = 6
) (
   input wire [NF-1:0] flags_cur,
   input wire [3*NF-1:0] modes,
   input wire [NF-1:0] result,
   input wire trap_clear,
   output reg [NF-1:0] flags_next
);
`include "ofd_map.vh"

   // ---------------------------------------------------------------
   // one flag through its mode
   // ---------------------------------------------------------------
   function upd_one;
      input cur;
      input [2:0] mode;
      input res;
      begin
         case (mode)
            `OFD_FM_NORMAL: upd_one = res;
            `OFD_FM_KEEP: upd_one = cur;
            `OFD_FM_CLRONLY: upd_one = cur & res;
            `OFD_FM_SETONLY: upd_one = cur | res;
            `OFD_FM_FORCE1: upd_one = 1'b1;
            `OFD_FM_FORCE0: upd_one = 1'b0;
            // undefined value allowed; holding is cheapest
            `OFD_FM_UNDEF: upd_one = cur;
            default: upd_one = cur;
         endcase
      end
   endfunction

   integer i;
   reg trap_base;

   always @* begin
      trap_base = 1'b0;
      for (i = 0; i < NF; i = i + 1) begin
         flags_next[i] = upd_one(flags_cur[i], modes[3*i +: 3], result[i]);
      end
      // trap flag: only trap instructions clear it, new overflow sets it
      trap_base = trap_clear ? 1'b0 : (flags_cur[`OFD_FLAG_TRAP] | flags_next[`OFD_FLAG_TRAP]);
      flags_next[`OFD_FLAG_TRAP] = trap_base | flags_next[`OFD_FLAG_V];
   end

endmodule
`default_nettype wire

// ==== dv/ofd_decoder_props.sv ====
// port-level assertion checker for the operand field decoder
`default_nettype none
`include "ofd_map.vh"
module ofd_decoder_props #(
   parameter AW = 6,
   parameter NF = 6
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [AW-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   input wire logic [NF-1:0] flag_word,
   input wire logic misaligned,
   input wire logic [15:0] branch_target
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // shadow of the written registers
   // ---------------------------------------------------------------
   logic [31:0] insn_h;
   logic [31:0] oper_h;
   logic [31:0] br_h;
   logic wr_ok;
   logic rd_dec;
   logic upd_any;
   logic mis_exp;
   logic [15:0] disp;
   logic [15:0] tgt_exp;
   logic [7:0] bit_mask;
   // shadows follow full-word writes only; lane tests touch unshadowed registers
   assign wr_ok = write && !waitrequest && byteenable == 4'hF;
   assign rd_dec = read && !waitrequest && address == `OFD_OFF_DECODE;
   assign upd_any = write && (address == `OFD_OFF_FLAGS || address == `OFD_OFF_FLAGUPD);
   assign mis_exp = (oper_h[10:8] == `OFD_KIND_BYTE) ? 1'h0 :
      (oper_h[10:8] == `OFD_KIND_WORD) ? oper_h[0] :
      (oper_h[10:8] == `OFD_KIND_DPTR) ? (oper_h[2:0] != 3'h0) :
      (oper_h[10:8] == 3'h7) ? 1'h1 : (oper_h[1:0] != 2'h0);
   assign disp = (insn_h[10:8] == `OFD_CLS_DISPX) ?
      {{5{insn_h[2]}}, insn_h[2:0], br_h[23:16]} : {{8{br_h[23]}}, br_h[23:16]};
   assign tgt_exp = br_h[15:0] + disp;
   assign bit_mask = 8'h01 << insn_h[2:0];
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         insn_h <= 32'h0;
         oper_h <= 32'h0;
         br_h <= 32'h0;
      end else if (wr_ok) begin
         if (address == `OFD_OFF_INSN) insn_h <= writedata;
         if (address == `OFD_OFF_OPERAND) oper_h <= writedata;
         if (address == `OFD_OFF_BRANCH) br_h <= writedata;
      end
   end
   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("waitrequest did not drop one cycle after a request");
   a_wait_short: assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest stayed low more than one cycle");
   a_wait_idle: assert property (!read && !write && waitrequest |=> waitrequest)
      else $error("waitrequest dropped with no request");
   a_trap_follows: assert property (flag_word[`OFD_FLAG_V] |-> flag_word[`OFD_FLAG_TRAP])
      else $error("trap flag clear while overflow flag set");
   a_mis_follows: assert property (1'h1 |-> misaligned == $past(mis_exp))
      else $error("misaligned output disagrees with operand alignment");
   a_target_follows: assert property (1'h1 |-> branch_target == $past(tgt_exp))
      else $error("branch target output wrong");
   a_flags_cause: assert property ($changed(flag_word) |->
      $past(upd_any) || $past(upd_any, 2) || $past(upd_any, 3))
      else $error("flags changed without a flag write");
   a_unmapped_zero: assert property (read && !waitrequest && address > `OFD_OFF_STEP
      |-> readdata == 32'h0)
      else $error("unmapped read returned nonzero");
   a_mode_select: assert property (rd_dec |-> readdata[2:0] ==
      ((insn_h[10:8] == `OFD_CLS_MODE) ? {1'h1, insn_h[1:0]} : 3'h0))
      else $error("addressing selector decode wrong");
   a_bit_select: assert property (rd_dec && insn_h[10:8] == `OFD_CLS_BIT
      |-> readdata[14:3] == {bit_mask, insn_h[2:0], 1'h1})
      else $error("bit select decode wrong");
endmodule
bind ofd_decoder ofd_decoder_props #(.AW(AW), .NF(NF)) u_props (.clk(clk), .nrst(nrst),
   .address(address), .read(read), .write(write), .writedata(writedata),
   .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
   .flag_word(flag_word), .misaligned(misaligned), .branch_target(branch_target));
`default_nettype wire

// ==== dv/ofd_fetch_model.sv ====
// bus master model of the fetch unit side
`default_nettype none
module ofd_fetch_model (
   input wire logic clk,
   input wire logic waitrequest,
   input wire logic [31:0] readdata,
   output logic [5:0] address,
   output logic read,
   output logic write,
   output logic [31:0] writedata,
   output logic [3:0] byteenable
);
   timeunit 1ns;
   timeprecision 1ps;
   int slow = 0;
   logic [3:0] lanes = 4'hF;
   initial begin
      address = 6'h3F;
      read = 1'h0;
      write = 1'h0;
      writedata = 32'h0;
      byteenable = 4'h0;
   end
   // ---------------------------------------------------------------
   // one transfer; slow adds idle cycles before the request
   // ---------------------------------------------------------------
   task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
      repeat (slow + 1) @(posedge clk);
      address <= a;
      write <= w;
      read <= !w;
      writedata <= wd;
      byteenable <= lanes;
      @(posedge clk);
      while (waitrequest !== 1'h0) begin
         @(posedge clk);
      end
      rd = readdata;
      read <= 1'h0;
      write <= 1'h0;
      // released lines flip so a stale value never passes for a live one
      address <= ~a;
      writedata <= ~wd;
   endtask
endmodule
`default_nettype wire

// ==== dv/ofd_decoder_tb.sv ====
// self-checking testbench of the operand field decoder
`default_nettype none
`include "ofd_map.vh"
module ofd_decoder_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'h0;
   logic nrst = 1'h0;
   logic [5:0] address;
   logic read;
   logic write;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic [3:0] byteenable;
   logic waitrequest;
   logic misaligned;
   logic [5:0] flag_word;
   logic [15:0] branch_target;
   int n_errors = 0;
   int comparisons = 0;
   always #10 clk = ~clk;
   ofd_decoder #(.AW(6), .NF(6)) DUT (.clk(clk), .nrst(nrst), .address(address),
      .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest), .flag_word(flag_word),
      .misaligned(misaligned), .branch_target(branch_target));
   ofd_fetch_model u_fetch (.clk(clk), .waitrequest(waitrequest), .readdata(readdata),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .byteenable(byteenable));
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task wr(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] x;
      u_fetch.xfer(1'h1, a, d, x);
   endtask
   task rd(input logic [5:0] a, output logic [31:0] d);
      u_fetch.xfer(1'h0, a, 32'h0, d);
   endtask
   task give_verdict;
      if (n_errors == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      logic [31:0] d;
      logic [5:0] offs [8] = '{`OFD_OFF_INSN, `OFD_OFF_OPERAND, `OFD_OFF_BRANCH,
         `OFD_OFF_TARGET, `OFD_OFF_FLAGS, `OFD_OFF_FLAGUPD, `OFD_OFF_OPDATA, `OFD_OFF_STEP};
      foreach (offs[i]) begin
         rd(offs[i], d);
         check("reset register", d, `OFD_RST_WORD);
      end
      check("reset ports", {flag_word, misaligned, branch_target}, 32'h0);
      wr(6'h24, 32'hFFFFFFFF);
      rd(6'h24, d);
      check("unmapped read", d, 32'h0);
      wr(`OFD_OFF_STEP, 32'hFFFFFFFF);
      rd(`OFD_OFF_STEP, d);
      check("read-only step", d, 32'h0);
   endtask
   task t_sel;
      logic [31:0] d;
      for (int c = 0; c < 4; c++) begin
         for (int s = 0; s < 4; s++) begin
            wr(`OFD_OFF_INSN, {21'h0, c[2:0], 6'h14, s[1:0]});
            rd(`OFD_OFF_DECODE, d);
            check("selector", d[2:0], (c == 1) ? {1'h1, s[1:0]} : 3'h0);
         end
      end
   endtask
   task t_bit;
      logic [31:0] d;
      for (int b = 0; b < 8; b++) begin
         wr(`OFD_OFF_INSN, {21'h0, `OFD_CLS_BIT, 5'h0A, b[2:0]});
         rd(`OFD_OFF_DECODE, d);
         check("bit select", d[14:3], {8'h01 << b, b[2:0], 1'h1});
      end
   endtask
   task automatic t_align; // rows {misaligned, kind, address}
      logic [31:0] d;
      logic [11:0] tab [14] = '{12'h0FF, 12'h001, 12'h1FE, 12'h901, 12'h2FC, 12'hAFE,
         12'hB02, 12'h3F0, 12'h404, 12'hD06, 12'h5FC, 12'h6F8, 12'hEFC, 12'hF00};
      foreach (tab[i]) begin
         wr(`OFD_OFF_OPERAND, {21'h0, tab[i][10:0]});
         rd(`OFD_OFF_DECODE, d);
         check("decode misaligned", d[15], tab[i][11]);
         check("misaligned port", misaligned, tab[i][11]);
      end
   endtask
   task automatic t_step; // rows {kind, data, stepped}
      logic [31:0] d;
      logic [66:0] tab [6] = '{{`OFD_KIND_PAIR, 32'h00010002, 32'h00020003},
         {`OFD_KIND_LONG, 32'h00010002, 32'h00010003},
         {`OFD_KIND_PAIR, 32'h0000FFFF, 32'h00010000},
         {`OFD_KIND_LONG, 32'h0000FFFF, 32'h00010000},
         {`OFD_KIND_TRIPLE, 32'hAB12FFFF, 32'h00130000},
         {`OFD_KIND_BYTE, 32'hAB12FFFF, 32'hAB12FFFF}};
      foreach (tab[i]) begin
         wr(`OFD_OFF_OPERAND, {21'h0, tab[i][66:64], 8'h00});
         wr(`OFD_OFF_OPDATA, tab[i][63:32]);
         rd(`OFD_OFF_STEP, d);
         check("stepped operand", d, tab[i][31:0]);
      end
      wr(`OFD_OFF_OPDATA, 32'h11223344);
      u_fetch.lanes = 4'h5;
      wr(`OFD_OFF_OPDATA, 32'hAABBCCDD);
      u_fetch.lanes = 4'hF;
      rd(`OFD_OFF_OPDATA, d);
      check("lane write", d, 32'h11BB33DD);
   endtask
   task automatic t_branch; // rows {class, opcode, target}; next 1000, low byte F0
      logic [31:0] d;
      logic [26:0] tab [5] = '{{`OFD_CLS_PLAIN, 8'h03, 16'h0FF0},
         {`OFD_CLS_DISPX, 8'h03, 16'h13F0}, {`OFD_CLS_DISPX, 8'h04, 16'h0CF0},
         {`OFD_CLS_DISPX, 8'h02, 16'h12F0}, {`OFD_CLS_MODE, 8'h07, 16'h0FF0}};
      wr(`OFD_OFF_BRANCH, 32'h00F01000);
      foreach (tab[i]) begin
         wr(`OFD_OFF_INSN, {21'h0, tab[i][26:16]});
         rd(`OFD_OFF_TARGET, d);
         check("target", d[15:0], tab[i][15:0]);
         check("target port", branch_target, tab[i][15:0]);
      end
   endtask
   task automatic t_flags; // rows {mode, start, result, expected} on the carry flag, rest kept
      logic [31:0] d;
      logic [17:0] m;
      logic [7:0] tab [12] = '{8'h03, 8'h04, 8'h15, 8'h12, 8'h24, 8'h22, 8'h33, 8'h35,
         8'h41, 8'h56, 8'h65, 8'h72};
      foreach (tab[i]) begin
         m = (18'h09249 & ~(18'h7 << 9)) | ({15'h0, tab[i][6:4]} << 9);
         wr(`OFD_OFF_FLAGS, {26'h0, 2'h2, tab[i][2], 3'h1});
         wr(`OFD_OFF_FLAGUPD, {8'h0, 2'h3, tab[i][1], 3'h5, m});
         rd(`OFD_OFF_FLAGS, d);
         check("flags", d[5:0], {2'h2, tab[i][0], 3'h1});
         check("flag port", flag_word, {2'h2, tab[i][0], 3'h1});
      end
   endtask
   task automatic t_trap; // overflow set, sticky trap, clear-only ignored, clear, set wins
      logic [31:0] d;
      logic [31:0] upd [5] = '{32'h00109209, 32'h00009209, 32'h00009251, 32'h01009249,
         32'h01109209};
      logic [5:0] exp [5] = '{6'h06, 6'h02, 6'h02, 6'h00, 6'h06};
      wr(`OFD_OFF_FLAGS, 32'h0);
      foreach (upd[i]) begin
         wr(`OFD_OFF_FLAGUPD, upd[i]);
         rd(`OFD_OFF_FLAGS, d);
         check("trap flags", d[5:0], exp[i]);
      end
   endtask
   initial begin
      repeat (3) @(posedge clk);
      nrst <= 1'h1;
      t_reset;
      t_sel;
      t_bit;
      t_align;
      t_step;
      t_branch;
      t_flags;
      // slow master: gaps between requests must not disturb the answers
      u_fetch.slow = 2;
      t_trap;
      give_verdict;
   end
   // run needs well under 3000 cycles
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      give_verdict;
   end
endmodule
`default_nettype wire
